// [hdl/sclr_top.sv]
// Functional notes
// RULE1: six-bit voltage select, resets to zero
// RULE2: codes 1b-1f,00-05 legal; others reserved
// RULE3: reserved bits read zero, writes ignored
// RULE4: soft reset writes gated by capability bits
// RULE5: reset bits PWM 20, ADC 16, watchdog 3
// RULE6: comparator, timers, encoder, serial reset bits
// RULE7: GPIO ports E..A reset at bits 4..0
// RULE8: raw status read-only, hardware set, zero reset
// RULE9: PLL lock flag bit 6
// RULE10: current limit flag bit 5
// RULE11: internal oscillator fault flag bit 4
// RULE12: main oscillator fault flag bit 3
// RULE13: regulator unregulated flag bit 2
// RULE14: brown-out flag bit 1, interrupt gated
// RULE15: PLL fault flag bit 0
// RULE16: capability bit one means peripheral present
// RULE17: interrupt from flag AND mask; W1C clears
// RULE18: brown-out signalled as reset when selected
// RULE19: soft reset bit one holds peripheral reset
// RULE20: flags stay set until cleared or reset
//
// The APB register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module sclr_top #(
  // presence of each peripheral, one per soft reset bit
  parameter logic [31:0] CAP_ONE = sclr_pkg::RST_A_BITS,
  parameter logic [31:0] CAP_TWO = sclr_pkg::RST_B_BITS,
  parameter logic [31:0] CAP_FOUR = sclr_pkg::RST_P_BITS
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [6:0] EVENT_SRC,
  output logic [5:0] VOUT_SELECT,
  output logic VOUT_CODE_OK,
  output logic [31:0] PERIPH_RESET_A,
  output logic [31:0] PERIPH_RESET_B,
  output logic [31:0] PORT_RESET,
  output logic SYS_IRQ,
  output logic BROWNOUT_RESET
);
  import sclr_pkg::*;

  sclr_reg_if rif (); // bus slave to register bank

  logic [5:0] vout_select; // regulator level code
  logic [31:0] rst_a; // peripheral soft reset a
  logic [31:0] rst_b; // peripheral soft reset b
  logic [31:0] rst_p; // gpio port soft reset
  logic [6:0] event_mask; // interrupt mask
  logic [15:0] bor_ctl; // brown-out control
  logic [6:0] raw; // sticky raw flags
  logic [6:0] ev_level; // synchronised event sources
  logic [6:0] ev_clear; // write-one-to-clear strobe
  logic [6:0] masked; // flags promoted to interrupt
  logic bor_sel; // brown-out gives reset, not interrupt

  // only bits both implemented and present accept writes
  localparam logic [31:0] ALLOW_A = RST_A_BITS & CAP_ONE; // RULE5
  localparam logic [31:0] ALLOW_B = RST_B_BITS & CAP_TWO; // RULE6
  localparam logic [31:0] ALLOW_P = RST_P_BITS & CAP_FOUR; // RULE7

  ////////////////////////////////////////////////////////////////
  // helpers

  // true for a write to the given register
  function automatic logic wr_to(input logic [11:0] ofs);
    wr_to = rif.wr_en && (rif.addr == ofs);
  endfunction

  // keep bits that may not change, take new ones where allowed
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] allow);
    merge = (old & ~allow) | (nw & allow);
  endfunction

  // voltage code inside one of the two documented runs
  function automatic logic code_legal(input logic [5:0] c);
    code_legal = (c <= VOUT_SELECT_LOW_TOP) ||
                 ((c >= VOUT_SELECT_HIGH_BASE) && (c <= VOUT_SELECT_HIGH_TOP));
  endfunction

  ////////////////////////////////////////////////////////////////
  // submodules

  sclr_apb_slave u_apb (
    .clk(MCLK),
    .rst_n(RESET_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pwdata(PWDATA),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .rif(rif.bus)
  );

  // event bit order matches the raw status layout
  sclr_raw_events #(.W(EV_W)) u_raw (
    .clk(MCLK),
    .rst_n(RESET_N),
    .src_async(EVENT_SRC), // RULE9 RULE10 RULE11 RULE12 RULE13 RULE15
    .clear(ev_clear),
    .level(ev_level),
    .flags(raw)
  );

  ////////////////////////////////////////////////////////////////
  // voltage select register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vout_select <= VOUT_SELECT_RST; // RULE1
    end else if (wr_to(OFS_VOUT_SELECT)) begin
      // reserved codes are stored; the legality flag reports them
      vout_select <= rif.wdata[5:0]; // RULE1
    end
  end

  ////////////////////////////////////////////////////////////////
  // soft reset registers, writes masked by presence
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_a <= RST_REG_RST;
      rst_b <= RST_REG_RST;
      rst_p <= RST_REG_RST;
    end else begin
      if (wr_to(OFS_RST_A)) begin
        rst_a <= merge(rst_a, rif.wdata, ALLOW_A); // RULE4
      end
      if (wr_to(OFS_RST_B)) begin
        rst_b <= merge(rst_b, rif.wdata, ALLOW_B); // RULE4
      end
      if (wr_to(OFS_RST_P)) begin
        rst_p <= merge(rst_p, rif.wdata, ALLOW_P); // RULE4
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // interrupt mask and brown-out control
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      event_mask <= EV_RST;
      bor_ctl <= BOR_CTL_RST;
    end else begin
      if (wr_to(OFS_MASK)) begin
        event_mask <= rif.wdata[6:0];
      end
      if (wr_to(OFS_BOR_CTL)) begin
        bor_ctl <= rif.wdata[15:0];
      end
    end
  end

  assign bor_sel = bor_ctl[BOR_SEL_BIT];
  // clear strobe from a masked-status write; set still wins
  assign ev_clear = wr_to(OFS_MSTAT) ? rif.wdata[6:0] : EV_RST; // RULE17
  // brown-out is kept off the interrupt while routed to reset
  always_comb begin
    masked = raw & event_mask; // RULE17
    masked[EV_BROWNOUT] = raw[EV_BROWNOUT] & event_mask[EV_BROWNOUT] & ~bor_sel; // RULE14
  end

  ////////////////////////////////////////////////////////////////
  // read decode; raw status has no write path of its own, only the masked-status clear
  always_comb begin
    rif.rdata = 32'h0000_0000; // RULE3
    rif.hit = 1'b1;
    case (rif.addr)
      OFS_CAP_ONE: rif.rdata = CAP_ONE; // RULE16
      OFS_CAP_TWO: rif.rdata = CAP_TWO; // RULE16
      OFS_CAP_FOUR: rif.rdata = CAP_FOUR; // RULE16
      OFS_BOR_CTL: rif.rdata[15:0] = bor_ctl;
      OFS_VOUT_SELECT: rif.rdata[5:0] = vout_select;
      OFS_RST_A: rif.rdata = rst_a;
      OFS_RST_B: rif.rdata = rst_b;
      OFS_RST_P: rif.rdata = rst_p;
      OFS_RAW: rif.rdata[6:0] = raw; // RULE8
      OFS_MASK: rif.rdata[6:0] = event_mask;
      OFS_MSTAT: rif.rdata[6:0] = masked;
      default: rif.hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // outputs to the rest of the chip
  assign VOUT_SELECT = vout_select;
  assign VOUT_CODE_OK = code_legal(vout_select); // RULE2
  // a one holds the peripheral in reset until written zero
  assign PERIPH_RESET_A = rst_a; // RULE19
  assign PERIPH_RESET_B = rst_b; // RULE19
  assign PORT_RESET = rst_p; // RULE19

  // registered so the controller never sees decode glitches
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SYS_IRQ <= 1'b0;
      BROWNOUT_RESET <= 1'b0;
    end else begin
      SYS_IRQ <= |masked; // RULE17
      // level follows the live brown-out, not the sticky flag
      BROWNOUT_RESET <= ev_level[EV_BROWNOUT] & bor_sel; // RULE18
    end
  end

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  property p_vout_select_write;
    wr_to(OFS_VOUT_SELECT) |=> (VOUT_SELECT == $past(rif.wdata[5:0]));
  endproperty
  a_vout_select_write: assert property (p_vout_select_write) else $error("voltage select not stored"); // RULE1

  property p_code_ok;
    (wr_to(OFS_VOUT_SELECT) && (rif.wdata[5:0] > VOUT_SELECT_LOW_TOP) && (rif.wdata[5:0] < VOUT_SELECT_HIGH_BASE))
      |=> !VOUT_CODE_OK;
  endproperty
  a_code_ok: assert property (p_code_ok) else $error("reserved code reported legal"); // RULE2

  property p_reserved_read;
    (rif.rd_en && !PWRITE && (rif.addr == OFS_RAW)) |=> (PRDATA[31:7] == 25'h0);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits not zero"); // RULE3

  property p_gate_a;
    wr_to(OFS_RST_A) |=> ((PERIPH_RESET_A & ~ALLOW_A) == ($past(PERIPH_RESET_A) & ~ALLOW_A));
  endproperty
  a_gate_a: assert property (p_gate_a) else $error("gated reset bit changed"); // RULE4

  property p_gate_p;
    wr_to(OFS_RST_P) |=> (PORT_RESET == ($past(rif.wdata) & ALLOW_P));
  endproperty
  a_gate_p: assert property (p_gate_p) else $error("port reset write wrong"); // RULE7

  property p_sticky;
    !wr_to(OFS_MSTAT) |=> ((raw & $past(raw)) == $past(raw));
  endproperty
  a_sticky: assert property (p_sticky) else $error("raw flag dropped without clear"); // RULE20

  property p_set;
    (ev_level != 7'h00) |=> ((raw & $past(ev_level)) == $past(ev_level));
  endproperty
  a_set: assert property (p_set) else $error("raw flag not set by event"); // RULE9

  property p_clear;
    wr_to(OFS_MSTAT) |=> ((raw & $past(rif.wdata[6:0]) & ~$past(ev_level)) == 7'h00);
  endproperty
  a_clear: assert property (p_clear) else $error("masked write did not clear flag"); // RULE17

  property p_bor_irq;
    ((raw == 7'h02) && bor_sel) |=> !SYS_IRQ;
  endproperty
  a_bor_irq: assert property (p_bor_irq) else $error("brown-out raised interrupt in reset mode"); // RULE14

  property p_bor_reset;
    (ev_level[EV_BROWNOUT] && bor_sel) |=> BROWNOUT_RESET;
  endproperty
  a_bor_reset: assert property (p_bor_reset) else $error("brown-out reset not signalled"); // RULE18

  property p_gate_a_set;
    wr_to(OFS_RST_A) |=> ((PERIPH_RESET_A & ALLOW_A) == ($past(rif.wdata) & ALLOW_A));
  endproperty
  a_gate_a_set: assert property (p_gate_a_set) else $error("present reset bit not written"); // RULE5

  property p_gate_b;
    wr_to(OFS_RST_B) |=> (PERIPH_RESET_B == ($past(rif.wdata) & ALLOW_B));
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("peripheral reset b write wrong"); // RULE6

  property p_reset_hold;
    !wr_to(OFS_RST_A) |=> $stable(PERIPH_RESET_A);
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("soft reset changed without write"); // RULE19

  property p_irq;
    (masked != 7'h00) |=> SYS_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("masked flag gave no interrupt"); // RULE17

  property p_bor_release;
    !ev_level[EV_BROWNOUT] |=> !BROWNOUT_RESET;
  endproperty
  a_bor_release: assert property (p_bor_release) else $error("brown-out reset without brown-out"); // RULE18

  property p_reserved_vout_select;
    (rif.rd_en && !PWRITE && (rif.addr == OFS_VOUT_SELECT)) |=> (PRDATA[31:6] == 26'h0);
  endproperty
  a_reserved_vout_select: assert property (p_reserved_vout_select) else $error("voltage reserved bits not zero"); // RULE3

  c_vout_select: cover property (wr_to(OFS_VOUT_SELECT) ##1 VOUT_CODE_OK);
  c_irq: cover property (!SYS_IRQ ##1 SYS_IRQ);
  c_clear: cover property (wr_to(OFS_MSTAT) && (raw != 7'h00));
  c_err: cover property (PSLVERR);
  c_bor_reset: cover property (BROWNOUT_RESET);
endmodule
`default_nettype wire

// [hdl/sclr_pkg.sv]
package sclr_pkg;
  // address width seen by this register group
  localparam int ADDR_W = 12;
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CAP_ONE = 12'h010;
  localparam logic [11:0] OFS_CAP_TWO = 12'h014;
  localparam logic [11:0] OFS_CAP_FOUR = 12'h01c;
  localparam logic [11:0] OFS_BOR_CTL = 12'h030;
  localparam logic [11:0] OFS_VOUT_SELECT = 12'h034;
  localparam logic [11:0] OFS_RST_A = 12'h040;
  localparam logic [11:0] OFS_RST_B = 12'h044;
  localparam logic [11:0] OFS_RST_P = 12'h048;
  localparam logic [11:0] OFS_RAW = 12'h050;
  localparam logic [11:0] OFS_MASK = 12'h054;
  localparam logic [11:0] OFS_MSTAT = 12'h058;
  // voltage adjust field
  localparam int VOUT_SELECT_W = 6;
  localparam logic [5:0] VOUT_SELECT_RST = 6'h00;
  localparam logic [5:0] VOUT_SELECT_LOW_TOP = 6'h05;
  localparam logic [5:0] VOUT_SELECT_HIGH_BASE = 6'h1b;
  localparam logic [5:0] VOUT_SELECT_HIGH_TOP = 6'h1f;
  // implemented reset-control bits of each soft reset register
  localparam logic [31:0] RST_A_BITS = 32'h0011_0008;
  localparam logic [31:0] RST_B_BITS = 32'h0107_0113;
  localparam logic [31:0] RST_P_BITS = 32'h0000_001f;
  localparam logic [31:0] RST_REG_RST = 32'h0000_0000;
  // raw event flags
  localparam int EV_W = 7;
  localparam logic [6:0] EV_RST = 7'h00;
  localparam int EV_PLL_LOCK = 6;
  localparam int EV_CUR_LIMIT = 5;
  localparam int EV_IOSC_FAULT = 4;
  localparam int EV_MOSC_FAULT = 3;
  localparam int EV_UNREG = 2;
  localparam int EV_BROWNOUT = 1;
  localparam int EV_PLL_FAULT = 0;
  // brown-out control: wait time 15:2, reset select 1, wait enable 0
  localparam logic [15:0] BOR_CTL_RST = 16'h7ffd;
  localparam int BOR_SEL_BIT = 1;
endpackage

// [hdl/sclr_reg_if.sv]
`timescale 1ns/1ns
`default_nettype none
// register access strobes between the bus slave and the register bank
interface sclr_reg_if;
  logic wr_en; // write takes effect at this edge
  logic rd_en; // setup phase of a transfer, read data is captured
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit; // address decodes to a register
  modport bus (output wr_en, rd_en, addr, wdata, input rdata, hit);
  modport regs (input wr_en, rd_en, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

// [hdl/sclr_apb_slave.sv]
`timescale 1ns/1ns
`default_nettype none
module sclr_apb_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sclr_reg_if.bus rif
);
  logic err_q; // decode miss caught in the setup cycle

  ////////////////////////////////////////////////////////////////
  // strobes: never a wait state, so access lasts one cycle
  assign rif.addr = paddr;
  assign rif.wdata = pwdata;
  assign rif.wr_en = psel & penable & pwrite;
  assign rif.rd_en = psel & ~penable;
  assign pready = psel & penable;
  // error only shown while the access completes
  assign pslverr = err_q & pready;

  ////////////////////////////////////////////////////////////////
  // read data and decode result registered at the setup edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (rif.rd_en) begin
      // writes return zero so stale data never leaks
      prdata <= pwrite ? 32'h0000_0000 : rif.rdata;
      err_q <= ~rif.hit;
    end
  end
endmodule
`default_nettype wire

// [hdl/sclr_raw_events.sv]
`timescale 1ns/1ns
`default_nettype none
module sclr_raw_events #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] src_async,
  input wire logic [W-1:0] clear,
  output logic [W-1:0] level,
  output logic [W-1:0] flags
);
  logic [W-1:0] meta; // first stage, read only by level

  ////////////////////////////////////////////////////////////////
  // two-stage synchroniser for the analog and clock monitors
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      level <= '0;
    end else begin
      meta <= src_async;
      level <= meta;
    end
  end

  ////////////////////////////////////////////////////////////////
  // sticky flags: a live source wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0; // RULE8
    end else begin
      flags <= (flags & ~clear) | level; // RULE20
    end
  end
endmodule
`default_nettype wire

// [verification/tb_sclr_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_sclr_top;
  import sclr_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // one peripheral left out of each capability set so write gating shows up
  localparam logic [31:0] CAP1 = RST_A_BITS & ~32'h0000_0008;
  localparam logic [31:0] CAP2 = RST_B_BITS & ~32'h0002_0000;
  localparam logic [31:0] CAP4 = RST_P_BITS & ~32'h0000_0004;
  localparam logic [11:0] OFS_HOLE = 12'h03c; // no register decodes here
  logic mclk = 1'b0; // 10 MHz system clock
  logic rst_n;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic [6:0] event_src; // raw hazard sources, active high
  logic [5:0] vout_select;
  logic vout_code_ok, sys_irq, brownout_reset;
  logic [31:0] periph_reset_a, periph_reset_b, port_reset;
  logic [31:0] q; // last read data
  logic e; // last error response
  int bad_count = 0;
  int n_checks = 0;

  // half period of 50 ns
  always #50 mclk = ~mclk;

  sclr_top #(.CAP_ONE(CAP1), .CAP_TWO(CAP2), .CAP_FOUR(CAP4)) uut (
    .MCLK(mclk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EVENT_SRC(event_src), .VOUT_SELECT(vout_select), .VOUT_CODE_OK(vout_code_ok),
    .PERIPH_RESET_A(periph_reset_a), .PERIPH_RESET_B(periph_reset_b), .PORT_RESET(port_reset),
    .SYS_IRQ(sys_irq), .BROWNOUT_RESET(brownout_reset));

  //////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, reached from the main sequence or a timeout
  task automatic final_report;
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // single value compare, case inequality so unknowns never pass
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("mismatch at %0t: no ready", $time);
      final_report();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // mapped write, expects no error response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(e), 32'h0000_0000);
  endtask

  // mapped read against an expected word
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
    chk(32'(e), 32'h0000_0000);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // a hang ends here rather than stalling the run
  initial begin
    repeat (50000) @(posedge mclk);
    bad_count++;
    $display("mismatch at %0t: run timeout", $time);
    final_report();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    event_src = 7'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values of the select, soft reset, raw status and capability registers
    rd_chk(OFS_VOUT_SELECT, 32'h0000_0000);
    rd_chk(OFS_RST_A, 32'h0000_0000);
    rd_chk(OFS_RST_B, 32'h0000_0000);
    rd_chk(OFS_RST_P, 32'h0000_0000);
    rd_chk(OFS_RAW, 32'h0000_0000);
    rd_chk(OFS_CAP_ONE, CAP1);
    rd_chk(OFS_CAP_TWO, CAP2);
    rd_chk(OFS_CAP_FOUR, CAP4);
    // every voltage code, with ones thrown at the reserved bits
    for (int c = 0; c < 64; c++) begin
      wr(OFS_VOUT_SELECT, 32'hffff_ffc0 | 32'(c));
      @(negedge mclk);
      chk(32'(vout_select), 32'(c));
      chk(32'(vout_code_ok), (c <= 5 || (c >= 27 && c <= 31)) ? 32'h0000_0001 : 32'h0000_0000);
    end
    rd_chk(OFS_VOUT_SELECT, 32'h0000_003f);
    // soft resets: all ones written, absent peripherals must stay clear
    wr(OFS_RST_A, 32'hffff_ffff);
    wr(OFS_RST_B, 32'hffff_ffff);
    wr(OFS_RST_P, 32'hffff_ffff);
    @(negedge mclk);
    chk(periph_reset_a, 32'h0011_0000);
    chk(periph_reset_b, 32'h0105_0113);
    chk(port_reset, 32'h0000_001b);
    rd_chk(OFS_RST_A, 32'h0011_0000);
    rd_chk(OFS_RST_B, 32'h0105_0113);
    rd_chk(OFS_RST_P, 32'h0000_001b);
    wr(OFS_RST_A, 32'h0000_0000);
    wr(OFS_RST_B, 32'h0000_0000);
    wr(OFS_RST_P, 32'h0000_0000);
    @(negedge mclk);
    chk(periph_reset_a | periph_reset_b | port_reset, 32'h0000_0000);
    // refusals: unmapped word, read-only registers
    apb(1'b1, OFS_HOLE, 32'hffff_ffff);
    chk(32'(e), 32'h0000_0001);
    apb(1'b0, OFS_HOLE, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    wr(OFS_RAW, 32'h0000_007f);
    rd_chk(OFS_RAW, 32'h0000_0000);
    wr(OFS_CAP_ONE, 32'h0000_0000);
    rd_chk(OFS_CAP_ONE, CAP1);
    // each event source: latch, stick, promote through mask, clear
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      event_src <= 7'h01 << i;
      repeat (3) @(posedge mclk);
      event_src <= 7'h00;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk(32'(sys_irq), 32'h0000_0000);
      rd_chk(OFS_RAW, 32'h1 << i);
      wr(OFS_MASK, 32'h1 << i);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk(32'(sys_irq), 32'h0000_0001);
      rd_chk(OFS_MSTAT, 32'h1 << i);
      wr(OFS_MSTAT, 32'h1 << i);
      rd_chk(OFS_RAW, 32'h0000_0000);
      wr(OFS_MASK, 32'h0000_0000);
    end
    // brown-out routed to reset: no interrupt even with its mask set
    wr(OFS_BOR_CTL, 32'h0000_7fff);
    wr(OFS_MASK, 32'h0000_0002);
    @(posedge mclk);
    event_src <= 7'h02;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(32'(brownout_reset), 32'h0000_0001);
    chk(32'(sys_irq), 32'h0000_0000);
    @(posedge mclk);
    event_src <= 7'h00;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk(32'(brownout_reset), 32'h0000_0000);
    rd_chk(OFS_RAW, 32'h0000_0002);
    // a second reset in mid-run wipes code and sticky flag
    wr(OFS_VOUT_SELECT, 32'h0000_001b);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(OFS_VOUT_SELECT, 32'h0000_0000);
    rd_chk(OFS_RAW, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
